// File: rtl/radio_address_crc_config.sv
// address select, crc framing and interframe spacing of the packet radio
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [RQ1] transmit every packet on the logical address in the transmit select register
// [RQ2] accept received packets on address i only when its enable bit is 1
// [RQ3] crc length 0: no crc computed, appended or checked; zero crc bytes
// [RQ4] crc length 1, 2, 3: crc of that many bytes, processing enabled
// [RQ5] software uses three crc bytes in both long-range modes
// [RQ6] coverage 0: address bytes feed the crc
// [RQ7] coverage 1: crc starts at first byte after the address
// [RQ8] coverage 2: crc starts at first byte after the length field
// [RQ9] crc register preloaded with initial value before first covered byte
// [RQ10] packets spaced by programmed microseconds, last bit to first bit
// [RQ11] configuration registers read zero after reset
// [RQ12] crc is a shift register on the polynomial, appended and compared
module radio_address_crc_config
  import radio_cfg_pkg::*;
#(
  parameter int unsigned ADDR_W = 12 // register address width
)(
  input  wire logic                    i_core_clk,        // system clock
  input  wire logic                    i_rst,             // sync reset, high
  input  wire logic [ADDR_W-1:0]       i_reg_addr,        // register byte address
  input  wire logic [31:0]             i_reg_wdata,       // write data
  input  wire logic                    i_reg_wr,          // write strobe
  input  wire logic                    i_reg_rd,          // read strobe
  output logic      [31:0]             o_reg_rdata,       // read data, next cycle
  input  wire logic                    i_tx_valid,        // tx beat offered
  input  wire radio_cfg_pkg::air_beat_t i_tx_beat,        // tx beat
  output logic                         o_tx_ready,        // tx beat taken
  output logic                         o_air_valid,       // beat on air
  output radio_cfg_pkg::air_beat_t     o_air_beat,        // beat on air
  output logic      [2:0]              o_tx_logical_addr, // address in use
  input  wire logic                    i_rx_valid,        // rx beat from air
  input  wire radio_cfg_pkg::air_beat_t i_rx_beat,        // rx beat
  input  wire logic [2:0]              i_rx_logical_addr, // matched address
  output logic                         o_rx_valid,        // accepted byte out
  output radio_cfg_pkg::air_beat_t     o_rx_beat,         // accepted byte
  output logic                         o_rx_done,         // rx packet ended
  output logic                         o_rx_accepted,     // last packet taken
  output logic                         o_rx_crc_ok        // last crc matched
);
  import radio_cfg_pkg::*;

  if (ADDR_W < 12)
  begin : g_bad
    $error("radio_address_crc_config: ADDR_W below 12");
  end

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BODY = 2'b01,
    TX_CRC  = 2'b10
  } tx_state_t;

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  logic [2:0]  tx_sel_q, tx_sel_d;
  logic [7:0]  rx_en_q, rx_en_d;
  logic [1:0]  crc_len_q, crc_len_d;
  logic [1:0]  crc_skip_q, crc_skip_d;
  logic [23:0] poly_q, poly_d;
  logic [23:0] init_q, init_d;
  logic [31:0] ifs_q, ifs_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;
  logic        crc_on;
  logic [23:0] mask;

  // software writes; reads latch into the answer register
  always_comb
  begin
    tx_sel_d   = tx_sel_q;
    rx_en_d    = rx_en_q;
    crc_len_d  = crc_len_q;
    crc_skip_d = crc_skip_q;
    poly_d     = poly_q;
    init_d     = init_q;
    ifs_d      = ifs_q;
    rdata_d    = RST_ZERO;
    if (i_reg_wr)
    begin
      unique case (i_reg_addr[11:0])
        OFF_TX_SEL:   tx_sel_d = i_reg_wdata[2:0];
        OFF_RX_EN:    rx_en_d  = i_reg_wdata[7:0];
        OFF_CRC_CFG:
        begin
          crc_len_d  = i_reg_wdata[CRC_LEN_LSB +: 2];
          crc_skip_d = i_reg_wdata[CRC_SKIP_LSB +: 2];
        end
        OFF_CRC_POLY: poly_d = i_reg_wdata[23:0];
        OFF_CRC_INIT: init_d = i_reg_wdata[23:0];
        OFF_IFS:      ifs_d  = i_reg_wdata;
        default:      ;
      endcase
    end
    if (i_reg_rd)
    begin
      unique case (i_reg_addr[11:0])
        OFF_TX_SEL:   rdata_d = {29'd0, tx_sel_q};
        OFF_RX_EN:    rdata_d = {24'd0, rx_en_q};
        OFF_CRC_CFG:  rdata_d = {22'd0, crc_skip_q, 6'd0, crc_len_q};
        OFF_CRC_POLY: rdata_d = {8'd0, poly_q};
        OFF_CRC_INIT: rdata_d = {8'd0, init_q};
        OFF_IFS:      rdata_d = ifs_q;
        OFF_STATUS:   rdata_d = status;
        default:      rdata_d = RST_ZERO; // unmapped reads zero
      endcase
    end
  end

  // every configuration register clears to zero
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      tx_sel_q   <= RST_ZERO[2:0]; // [RQ11]
      rx_en_q    <= RST_ZERO[7:0];
      crc_len_q  <= RST_ZERO[1:0];
      crc_skip_q <= RST_ZERO[1:0];
      poly_q     <= RST_ZERO[23:0];
      init_q     <= RST_ZERO[23:0];
      ifs_q      <= RST_ZERO;
      rdata_q    <= RST_ZERO;
    end
    else
    begin
      tx_sel_q   <= tx_sel_d;
      rx_en_q    <= rx_en_d;
      crc_len_q  <= crc_len_d;
      crc_skip_q <= crc_skip_d;
      poly_q     <= poly_d;
      init_q     <= init_d;
      ifs_q      <= ifs_d;
      rdata_q    <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign crc_on      = (crc_len_q != 2'd0); // [RQ3] [RQ4]
  assign mask        = (crc_len_q == 2'd1) ? 24'h00_00ff :
                       (crc_len_q == 2'd2) ? 24'h00_ffff : 24'hff_ffff;

  // which field kinds feed the crc under the coverage setting
  function automatic logic covered(input field_kind_t k, input logic [1:0] s);
    unique case (s)
      COVER_ALL:             covered = (k != KIND_CRC); // [RQ6]
      COVER_SKIP_ADDR:       covered = (k != KIND_CRC) && (k != KIND_ADDR); // [RQ7]
      CRC_AFTER_LENGTH_MODE: covered = (k == KIND_BODY); // [RQ8]
      default:               covered = (k != KIND_CRC);
    endcase
  endfunction : covered

  // -----------------------------------------------------------------
  // transmit path
  // -----------------------------------------------------------------
  tx_state_t   tx_state_q, tx_state_d;
  logic [1:0]  tx_cnt_q, tx_cnt_d;
  logic        air_valid_q, air_valid_d;
  air_beat_t   air_q, air_d;
  logic [2:0]  tx_addr_q, tx_addr_d;
  logic        tx_take, tx_load, tx_shift;
  logic [23:0] tx_crc;
  logic [7:0]  tx_crc_byte;
  logic        ifs_done, ifs_start;

  // a new packet only starts once the gap has elapsed
  assign o_tx_ready = (tx_state_q == TX_IDLE) ? ifs_done : (tx_state_q == TX_BODY);
  assign tx_take    = i_tx_valid && o_tx_ready;
  assign tx_load    = tx_take && (tx_state_q == TX_IDLE) && crc_on; // [RQ9]
  assign tx_shift   = tx_take && crc_on && covered(i_tx_beat.kind, crc_skip_q);
  assign tx_crc_byte = (tx_cnt_q == 2'd2) ? tx_crc[23:16] :
                       (tx_cnt_q == 2'd1) ? tx_crc[15:8] : tx_crc[7:0];

  // payload beats pass through, then the crc bytes, msb first
  always_comb
  begin
    tx_state_d  = tx_state_q;
    tx_cnt_d    = tx_cnt_q;
    tx_addr_d   = tx_addr_q;
    air_valid_d = 1'b0;
    air_d       = air_q;
    unique case (tx_state_q)
      TX_IDLE, TX_BODY:
        if (tx_take)
        begin
          if (tx_state_q == TX_IDLE)
            tx_addr_d = tx_sel_q; // [RQ1]
          air_valid_d = 1'b1;
          air_d       = i_tx_beat;
          air_d.last  = i_tx_beat.last && !crc_on; // [RQ3]
          tx_cnt_d    = crc_len_q - 2'd1;
          if (!i_tx_beat.last)
            tx_state_d = TX_BODY;
          else
            tx_state_d = crc_on ? TX_CRC : TX_IDLE;
        end
      TX_CRC:
      begin
        air_valid_d = 1'b1;
        air_d.data  = tx_crc_byte; // [RQ12]
        air_d.kind  = KIND_CRC;
        air_d.last  = (tx_cnt_q == 2'd0); // [RQ4]
        tx_cnt_d    = tx_cnt_q - 2'd1;
        if (tx_cnt_q == 2'd0)
          tx_state_d = TX_IDLE;
      end
      default: tx_state_d = TX_IDLE;
    endcase
  end

  // register only
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      tx_state_q  <= TX_IDLE;
      tx_cnt_q    <= 2'd0;
      tx_addr_q   <= 3'd0;
      air_valid_q <= 1'b0;
      air_q       <= '0;
    end
    else
    begin
      tx_state_q  <= tx_state_d;
      tx_cnt_q    <= tx_cnt_d;
      tx_addr_q   <= tx_addr_d;
      air_valid_q <= air_valid_d;
      air_q       <= air_d;
    end
  end

  assign o_air_valid       = air_valid_q;
  assign o_air_beat        = air_q;
  assign o_tx_logical_addr = tx_addr_q;

  crc_shift_unit u_tx_crc (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_load     (tx_load),
    .i_shift    (tx_shift),
    .i_byte     (i_tx_beat.data),
    .i_len      (crc_len_q),
    .i_init     (init_q),
    .i_poly     (poly_q),
    .o_crc      (tx_crc)
  );

  // -----------------------------------------------------------------
  // receive path
  // -----------------------------------------------------------------
  logic        rx_busy_q, rx_busy_d;
  logic        rx_acc_q, rx_acc_d;
  logic [23:0] got_q, got_d;
  logic        rx_valid_q, rx_valid_d;
  air_beat_t   rx_beat_q, rx_beat_d;
  logic        done_q, done_d, accepted_q, accepted_d, ok_q, ok_d;
  logic        rx_acc_now, rx_load, rx_shift, rx_end;
  logic [23:0] rx_crc;

  // the address decision is made on the first beat and held to the end
  assign rx_acc_now = rx_busy_q ? rx_acc_q : rx_en_q[i_rx_logical_addr]; // [RQ2]
  assign rx_load    = i_rx_valid && !rx_busy_q && rx_acc_now && crc_on;
  assign rx_shift   = i_rx_valid && rx_acc_now && crc_on &&
                      covered(i_rx_beat.kind, crc_skip_q);
  assign rx_end     = i_rx_valid && i_rx_beat.last;

  // collect received crc bytes and compare at the last beat
  always_comb
  begin
    rx_busy_d  = i_rx_valid ? !i_rx_beat.last : rx_busy_q;
    rx_acc_d   = i_rx_valid ? rx_acc_now : rx_acc_q;
    got_d      = got_q;
    if (i_rx_valid && !rx_busy_q)
      got_d = 24'h00_0000;
    if (i_rx_valid && i_rx_beat.kind == KIND_CRC)
      got_d = {got_d[15:0], i_rx_beat.data};
    rx_valid_d = i_rx_valid && rx_acc_now && (i_rx_beat.kind != KIND_CRC);
    rx_beat_d  = rx_valid_d ? i_rx_beat : rx_beat_q;
    done_d     = rx_end;
    accepted_d = rx_end ? rx_acc_now : accepted_q;
    ok_d       = ok_q;
    if (rx_end)
      ok_d = rx_acc_now && (!crc_on || ((got_d & mask) == rx_crc)); // [RQ12]
  end

  // register only
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rx_busy_q  <= 1'b0;
      rx_acc_q   <= 1'b0;
      got_q      <= 24'h00_0000;
      rx_valid_q <= 1'b0;
      rx_beat_q  <= '0;
      done_q     <= 1'b0;
      accepted_q <= 1'b0;
      ok_q       <= 1'b0;
    end
    else
    begin
      rx_busy_q  <= rx_busy_d;
      rx_acc_q   <= rx_acc_d;
      got_q      <= got_d;
      rx_valid_q <= rx_valid_d;
      rx_beat_q  <= rx_beat_d;
      done_q     <= done_d;
      accepted_q <= accepted_d;
      ok_q       <= ok_d;
    end
  end

  assign o_rx_valid    = rx_valid_q;
  assign o_rx_beat     = rx_beat_q;
  assign o_rx_done     = done_q;
  assign o_rx_accepted = accepted_q;
  assign o_rx_crc_ok   = ok_q;

  crc_shift_unit u_rx_crc (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_load     (rx_load),
    .i_shift    (rx_shift),
    .i_byte     (i_rx_beat.data),
    .i_len      (crc_len_q),
    .i_init     (init_q),
    .i_poly     (poly_q),
    .o_crc      (rx_crc)
  );

  // -----------------------------------------------------------------
  // interframe gap: restarted at the last beat of any packet
  // -----------------------------------------------------------------
  assign ifs_start = (air_valid_d && air_d.last) || rx_end; // [RQ10]

  ifs_gap_timer #(
    .CYC_US (CYC_PER_US),
    .US_W   (32)
  ) u_gap (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (ifs_start),
    .i_us       (ifs_q),
    .o_done     (ifs_done)
  );

  // status word: block state visible to software
  assign status = {27'd0, ok_q, accepted_q, rx_busy_q, !ifs_done,
                   (tx_state_q != TX_IDLE)};

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_TX_ADDR: assert property ( // [RQ1]
    (tx_take && tx_state_q == TX_IDLE) |=> (o_tx_logical_addr == $past(tx_sel_q)))
    else $error("tx address not taken from select register");
  AST_RX_DROP: assert property ( // [RQ2]
    (i_rx_valid && !rx_busy_q && !rx_en_q[i_rx_logical_addr]) |=> !o_rx_valid)
    else $error("byte forwarded on disabled address");
  AST_NO_CRC: assert property ( // [RQ3]
    (crc_len_q == 2'd0 && $stable(crc_len_q)) |=> !(o_air_valid && o_air_beat.kind == KIND_CRC))
    else $error("crc byte sent with crc disabled");
  AST_CRC_TWO: assert property ( // [RQ4]
    (tx_take && i_tx_beat.last && crc_len_q == 2'd2) |=> o_air_valid
      ##1 (o_air_valid && o_air_beat.kind == KIND_CRC && !o_air_beat.last)
      ##1 (o_air_valid && o_air_beat.kind == KIND_CRC && o_air_beat.last))
    else $error("two byte crc not appended");
  AST_COVER_ADDR: assert property ( // [RQ6]
    (tx_take && crc_on && crc_skip_q == 2'd0 && i_tx_beat.kind == KIND_ADDR) |-> tx_shift)
    else $error("address not covered");
  AST_SKIP_ADDR: assert property ( // [RQ7]
    (tx_take && crc_skip_q == 2'd1 && i_tx_beat.kind == KIND_ADDR) |-> !tx_shift)
    else $error("address fed to crc while skipped");
  AST_AFTER_LEN: assert property ( // [RQ8]
    (tx_take && crc_skip_q == 2'd2 && i_tx_beat.kind != KIND_BODY) |-> !tx_shift)
    else $error("header fed to crc in after-length mode");
  AST_RESET_ZERO: assert property (disable iff (1'b0) // [RQ11]
    i_rst |=> (tx_sel_q == 3'd0 && rx_en_q == 8'd0 && crc_len_q == 2'd0 &&
               init_q == 24'd0 && ifs_q == 32'd0))
    else $error("configuration not zero after reset");
  AST_RX_CHECK: assert property ( // [RQ12]
    (rx_end && rx_acc_now && crc_on && (got_d & mask) != rx_crc) |=> !o_rx_crc_ok)
    else $error("bad crc reported good");

  COV_TX_CRC:  cover property (o_air_valid && o_air_beat.kind == KIND_CRC && o_air_beat.last);
  COV_RX_OK:   cover property (o_rx_done && o_rx_accepted && o_rx_crc_ok);
  COV_RX_DROP: cover property (o_rx_done && !o_rx_accepted);

endmodule : radio_address_crc_config

`default_nettype wire

// File: rtl/radio_cfg_pkg.sv
// shared constants, field layouts and carrier types of the address/crc/spacing block
package radio_cfg_pkg;

  // -----------------------------------------------------------------
  // clock and timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;

  // -----------------------------------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [11:0] OFF_TX_SEL   = 12'h52c;
  localparam logic [11:0] OFF_RX_EN    = 12'h530;
  localparam logic [11:0] OFF_CRC_CFG  = 12'h534;
  localparam logic [11:0] OFF_CRC_POLY = 12'h538;
  localparam logic [11:0] OFF_CRC_INIT = 12'h53c;
  localparam logic [11:0] OFF_IFS      = 12'h544;
  localparam logic [11:0] OFF_STATUS   = 12'h5f0;

  // -----------------------------------------------------------------
  // field positions and reset values
  // -----------------------------------------------------------------
  localparam int          CRC_LEN_LSB  = 0;
  localparam int          CRC_SKIP_LSB = 8;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_ADDR = 3'b000,
    KIND_HDR  = 3'b001,
    KIND_LEN  = 3'b010,
    KIND_BODY = 3'b011,
    KIND_CRC  = 3'b100
  } field_kind_t;

  typedef enum logic [1:0] {
    COVER_ALL             = 2'b00,
    COVER_SKIP_ADDR       = 2'b01,
    CRC_AFTER_LENGTH_MODE = 2'b10
  } crc_cover_t;

  typedef struct packed {
    logic [7:0]  data;
    field_kind_t kind;
    logic        last;
  } air_beat_t;

endpackage : radio_cfg_pkg

// File: rtl/crc_shift_unit.sv
// programmable crc shift register of one to three bytes, one byte per cycle
`timescale 1ns/1ns
`default_nettype none

module crc_shift_unit
  import radio_cfg_pkg::*;
(
  input  wire logic        i_core_clk, // system clock
  input  wire logic        i_rst,      // sync reset, high
  input  wire logic        i_load,     // preload from initial value
  input  wire logic        i_shift,    // feed one byte
  input  wire logic [7:0]  i_byte,     // byte fed, msb first
  input  wire logic [1:0]  i_len,      // crc length in bytes
  input  wire logic [23:0] i_init,     // initial value
  input  wire logic [23:0] i_poly,     // polynomial
  output logic      [23:0] o_crc       // current crc
);
  logic [23:0] crc_q;
  logic [23:0] crc_d;
  logic [23:0] mask;
  logic [23:0] val;
  logic        fb;

  // -----------------------------------------------------------------
  // next value: bit-serial update unrolled over one byte
  // -----------------------------------------------------------------
  always_comb
  begin
    mask = (i_len == 2'd1) ? 24'h00_00ff :
           (i_len == 2'd2) ? 24'h00_ffff : 24'hff_ffff;
    val  = (i_load ? i_init : crc_q) & mask; // [RQ9]
    fb   = 1'b0;
    for (int b = 7; b >= 0; b--)
    begin
      fb  = i_byte[b] ^ ((i_len == 2'd1) ? val[7] :
                         (i_len == 2'd2) ? val[15] : val[23]);
      val = ((val << 1) ^ (fb ? i_poly : 24'h00_0000)) & mask; // [RQ12]
    end
    if (i_shift)
      crc_d = val;
    else if (i_load)
      crc_d = i_init & mask;
    else
      crc_d = crc_q;
  end

  // register only
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      crc_q <= RST_ZERO[23:0];
    else
      crc_q <= crc_d;
  end

  assign o_crc = crc_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_CRC_PRELOAD: assert property ( // [RQ9]
    (i_load && !i_shift) |=> (o_crc == $past(i_init & mask)))
    else $error("crc not preloaded from initial value");

endmodule : crc_shift_unit

`default_nettype wire

// File: rtl/ifs_gap_timer.sv
// interframe gap timer counting whole microseconds of system clock
`timescale 1ns/1ns
`default_nettype none

module ifs_gap_timer
  import radio_cfg_pkg::*;
#(
  parameter int unsigned CYC_US = CYC_PER_US, // cycles per microsecond
  parameter int unsigned US_W   = 32          // width of gap value
)(
  input  wire logic            i_core_clk, // system clock
  input  wire logic            i_rst,      // sync reset, high
  input  wire logic            i_start,    // packet just ended
  input  wire logic [US_W-1:0] i_us,       // gap in microseconds
  output logic                 o_done      // gap elapsed
);
  localparam int CW = $clog2(CYC_US + 1);

  if (CYC_US < 1 || US_W < 1)
  begin : g_bad
    $error("ifs_gap_timer: bad parameters");
  end

  logic [US_W-1:0] us_q, us_d;
  logic [CW-1:0]   cyc_q, cyc_d;

  // -----------------------------------------------------------------
  // count down microseconds; a restart simply reloads
  // -----------------------------------------------------------------
  always_comb
  begin
    us_d  = us_q;
    cyc_d = cyc_q;
    if (i_start)
    begin
      us_d  = i_us;
      cyc_d = '0;
    end
    else if (us_q != '0)
    begin
      if (cyc_q == CW'(CYC_US - 1))
      begin
        cyc_d = '0;
        us_d  = us_q - 1'b1;
      end
      else
        cyc_d = cyc_q + 1'b1;
    end
  end

  // register only
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      us_q  <= '0;
      cyc_q <= '0;
    end
    else
    begin
      us_q  <= us_d;
      cyc_q <= cyc_d;
    end
  end

  assign o_done = (us_q == '0); // [RQ10]

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_IFS_ONE_US: assert property ( // [RQ10]
    (i_start && i_us == 1 && CYC_US == 125) |=> (!o_done && !i_start) [*3] ##123 o_done)
    else $error("one microsecond gap not 125 cycles");

endmodule : ifs_gap_timer

`default_nettype wire

// File: dv/remote_radio_model.sv
// far-side radio: records beats sent on air and sends packets to the receive side
`timescale 1ns/1ns
`default_nettype none

module remote_radio_model
  import radio_cfg_pkg::*;
(
  input  wire logic      i_core_clk,  // system clock
  input  wire logic      i_air_valid, // beat from device
  input  wire air_beat_t i_air_beat,  // beat from device
  output logic           o_rx_valid,  // beat to device
  output air_beat_t      o_rx_beat,   // beat to device
  output logic [2:0]     o_rx_addr    // matched address index
);
  logic [7:0] q [$];
  int         cyc      = 0;
  int         last_end = -1;
  int         gap      = -1;

  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_beat  = '0;
    o_rx_addr  = 3'h0;
  end

  // capture air bytes and the spacing from one packet end to the next start
  always @(posedge i_core_clk)
  begin
    cyc = cyc + 1;
    if (i_air_valid === 1'b1)
    begin
      q.push_back(i_air_beat.data);
      if (i_air_beat.kind == KIND_ADDR && last_end >= 0)
        gap = cyc - last_end;
      if (i_air_beat.last)
        last_end = cyc;
    end
  end

  // back-to-back beats; a released bus shows the inverse
  task automatic send(input logic [2:0] a, input logic [7:0] d [], input field_kind_t k []);
    for (int i = 0; i < d.size(); i++)
    begin
      @(posedge i_core_clk);
      o_rx_valid <= 1'b1;
      o_rx_addr  <= a;
      o_rx_beat  <= '{data: d[i], kind: k[i], last: (i == d.size() - 1)};
    end
    @(posedge i_core_clk);
    o_rx_valid <= 1'b0;
    o_rx_beat  <= ~o_rx_beat;
  endtask : send
endmodule : remote_radio_model
`default_nettype wire

// File: dv/radio_address_crc_config_tb.sv
// self-checking bench for address select, crc framing and interframe spacing
`timescale 1ns/1ns
`default_nettype none

module radio_address_crc_config_tb;
  import radio_cfg_pkg::*;
  localparam logic [23:0] POLY = 24'h80_0063; // arbitrary test polynomial
  localparam logic [23:0] INIT = 24'h55_5555;
  logic        i_core_clk, i_rst, i_reg_wr, i_reg_rd, i_tx_valid, o_tx_ready, o_air_valid;
  logic        rx_valid, o_rx_valid, o_rx_done, o_rx_accepted, o_rx_crc_ok;
  logic [11:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, v;
  logic [2:0]  o_tx_logical_addr, rx_addr;
  air_beat_t   i_tx_beat, o_air_beat, rx_beat, o_rx_beat;
  logic [23:0] e;
  logic [7:0]  pd [4] = '{8'ha5, 8'h02, 8'h3c, 8'hc3};
  field_kind_t pk [4] = '{KIND_ADDR, KIND_LEN, KIND_BODY, KIND_BODY};
  logic [11:0] offs [7] = '{OFF_TX_SEL, OFF_RX_EN, OFF_CRC_CFG, OFF_CRC_POLY,
                            OFF_CRC_INIT, OFF_IFS, 12'h600};
  logic [7:0]  rxd [];
  field_kind_t rxk [];
  int          fail_count = 0;
  int          checks = 0;
  int          rxn, w;

  radio_address_crc_config radio_address_crc_config_i (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_tx_valid(i_tx_valid),
    .i_tx_beat(i_tx_beat), .o_tx_ready(o_tx_ready), .o_air_valid(o_air_valid),
    .o_air_beat(o_air_beat), .o_tx_logical_addr(o_tx_logical_addr), .i_rx_valid(rx_valid),
    .i_rx_beat(rx_beat), .i_rx_logical_addr(rx_addr), .o_rx_valid(o_rx_valid),
    .o_rx_beat(o_rx_beat), .o_rx_done(o_rx_done), .o_rx_accepted(o_rx_accepted),
    .o_rx_crc_ok(o_rx_crc_ok));
  remote_radio_model remote_radio_model_i (.i_core_clk(i_core_clk), .i_air_valid(o_air_valid),
    .i_air_beat(o_air_beat), .o_rx_valid(rx_valid), .o_rx_beat(rx_beat), .o_rx_addr(rx_addr));

  // -----------------------------------------------------------------
  // clock, checks and bus tasks
  // -----------------------------------------------------------------
  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk)
    if (o_rx_valid === 1'b1)
    begin
      chk(o_rx_beat.data, pd[rxn]);
      rxn = rxn + 1;
    end

  task automatic complete_run;
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // a spent wait bound fails the run
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      complete_run();
    end
  endtask : tmo

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd   <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : rd

  // msb-first crc over an n-byte register
  function automatic logic [23:0] pkt_crc(input int n, input int cov);
    logic [23:0] m;
    logic [23:0] c;
    logic        fb;
    m = 24'((25'h1 << (8 * n)) - 25'h1);
    c = INIT & m;
    for (int i = 0; i < 4; i++)
      if (cov == 0 || (cov == 1 && i > 0) || pk[i] == KIND_BODY)
        for (int b = 7; b >= 0; b--)
        begin
          fb = c[8 * n - 1] ^ pd[i][b];
          c  = (c << 1) & m;
          if (fb)
            c = c ^ (POLY & m);
        end
    return c;
  endfunction : pkt_crc

  // each beat held until ready is sampled high
  task automatic tx_pkt;
    for (int i = 0; i < 4; i++)
    begin
      i_tx_valid <= 1'b1;
      i_tx_beat  <= '{data: pd[i], kind: pk[i], last: (i == 3)};
      w = 0;
      do
      begin
        @(posedge i_core_clk);
        w++;
      end while (o_tx_ready !== 1'b1 && w < 2000);
      tmo(w, 2000);
    end
    i_tx_valid <= 1'b0;
  endtask : tx_pkt

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    {i_rst, i_reg_wr, i_reg_rd, i_tx_valid} = 4'hf;
    {i_reg_wr, i_reg_rd, i_tx_valid} = 3'h0;
    i_reg_addr  = 12'h000;
    i_reg_wdata = 32'h0000_0000;
    i_tx_beat   = '0;
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    foreach (offs[i])
    begin
      rd(offs[i], v);
      chk(v, 32'h0000_0000);
    end
    wr(OFF_CRC_POLY, 32'(POLY));
    wr(OFF_CRC_INIT, 32'(INIT));
    wr(OFF_IFS, 32'h0000_0001);
    // each length and coverage code, new address per packet; no long-range mode
    for (int l = 0; l < 4; l++)
    begin
      wr(OFF_TX_SEL, 32'(l + 4));
      wr(OFF_CRC_CFG, 32'(((l % 3) << 8) | l));
      remote_radio_model_i.q.delete();
      @(posedge i_core_clk);
      tx_pkt();
      repeat (8) @(posedge i_core_clk);
      chk(o_tx_logical_addr, 32'(l + 4));
      chk(remote_radio_model_i.q.size(), 32'(4 + l));
      e = pkt_crc(l, l % 3);
      for (int j = 0; j < l; j++)
        chk(remote_radio_model_i.q[4 + j], e[8 * (l - j) - 1 -: 8]);
      if (l > 0)
        chk(remote_radio_model_i.gap >= 122 && remote_radio_model_i.gap <= 131, 1);
    end
    // receive: enabled address, disabled address, corrupted crc
    wr(OFF_RX_EN, 32'h0000_0008);
    wr(OFF_CRC_CFG, 32'h0000_0002);
    e = pkt_crc(2, 0);
    rxd = new[6];
    rxk = new[6];
    foreach (pd[i])
    begin
      rxd[i] = pd[i];
      rxk[i] = pk[i];
    end
    for (int r = 0; r < 3; r++)
    begin
      repeat (130) @(posedge i_core_clk);
      rxd[4] = e[15:8];
      rxd[5] = e[7:0] ^ ((r == 2) ? 8'h01 : 8'h00);
      rxk[4] = KIND_CRC;
      rxk[5] = KIND_CRC;
      rxn = 0;
      remote_radio_model_i.send((r == 1) ? 3'h4 : 3'h3, rxd, rxk);
      w = 0;
      while (o_rx_done !== 1'b1 && w < 50)
      begin
        @(posedge i_core_clk);
        w++;
      end
      tmo(w, 50);
      chk(o_rx_accepted, (r != 1));
      chk(o_rx_crc_ok, (r == 0));
      chk(rxn, (r == 1) ? 0 : 4);
    end
    complete_run();
  end
endmodule : radio_address_crc_config_tb
`default_nettype wire
